// file: hdl/hppm_top.sv
// module: host pin mux with report pending interrupt
`timescale 1ns/10ps
`default_nettype none
module hppm_top
    import hppm_pkg::*;
(
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // mode strap and reports
    input wire logic [1:0] i_mode_sel,
    input wire logic i_report_push,
    input wire logic i_report_consume,
    input wire logic i_lin_irq_as_enable,
    input wire logic i_lin_transceiver_enable,
    // shared pin a
    input wire logic i_host_shared_pin_a,
    output logic o_host_shared_pin_a,
    output logic o_host_shared_pin_a_oe_n,
    // shared pin b
    input wire logic i_host_shared_pin_b,
    output logic o_host_shared_pin_b,
    output logic o_host_shared_pin_b_oe_n,
    // interrupt pin, open drain
    output logic o_report_pending_irq_n,
    output logic o_report_pending_irq_n_oe_n,
    // core side of shared pins
    input wire logic i_i2c_sda_out,
    input wire logic i_i2c_sda_drive_low,
    input wire logic i_i2c_scl_drive_low,
    input wire logic i_lin_tx,
    output logic o_i2c_sda_in,
    output logic o_i2c_scl_in,
    output logic o_spi_sck,
    output logic o_spi_select_n,
    output logic o_lin_rx,
    output logic [2:0] o_mode,
    output logic [7:0] o_reports_pending,
    // general purpose pins
    input wire logic [HPPM_GPIO_W-1:0] i_gpio,
    output logic [HPPM_GPIO_W-1:0] o_gpio,
    output logic [HPPM_GPIO_W-1:0] o_gpio_oe_n,
    input wire logic [HPPM_GPIO_W-1:0] i_gpio_dir_out,
    input wire logic [HPPM_GPIO_W-1:0] i_gpio_value,
    output logic [HPPM_GPIO_W-1:0] o_gpio_value,
    // sync selection
    input wire logic i_hsync_enable,
    input wire logic i_external_sync_enable,
    output logic o_hsync,
    output logic o_external_sync_in
);
    import hppm_pkg::*;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic mode_latched_reg;
    hppm_mode_e mode_reg;
    hppm_mode_e mode_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [HPPM_GPIO_W-1:0] gpio_dir_reg;
    logic [HPPM_GPIO_W-1:0] gpio_out_reg;
    logic [HPPM_GPIO_W-1:0] gpio_in_reg;
    logic [1:0] sync_reg;
    logic is_i2c;
    logic is_spi;
    logic is_lin;
    logic irq_as_enable;
    logic pending;
    logic do_push;
    logic do_pop;

    hppm_sync_if sync ();

    // reset release through two stages
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_reg <= HPPM_RST_SYNC_INIT;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    hppm_sync2 u_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_pin_a(i_host_shared_pin_a),
        .i_pin_b(i_host_shared_pin_b),
        .i_gpio(i_gpio),
        .sync(sync)
    );

    function automatic hppm_mode_e decode_mode(input logic [1:0] sel);
        case (sel)
            HPPM_MODE_SEL_SPI: decode_mode = HPPM_MODE_SPI;
            HPPM_MODE_SEL_LIN: decode_mode = HPPM_MODE_LIN;
            default: decode_mode = HPPM_MODE_I2C;
        endcase
    endfunction

    assign mode_next = decode_mode(i_mode_sel);

    // strap caught once after reset release
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_latched_reg <= 1'b0;
            mode_reg <= HPPM_MODE_I2C;
        end else if (i_ce && !mode_latched_reg) begin
            mode_latched_reg <= 1'b1;
            mode_reg <= mode_next;
        end
    end

    assign is_i2c = (mode_reg == HPPM_MODE_I2C);
    assign is_spi = (mode_reg == HPPM_MODE_SPI);
    assign is_lin = (mode_reg == HPPM_MODE_LIN);

    // pending report count, push and consume together keep count unless it is zero or full
    assign do_push = i_report_push && (count_reg != HPPM_COUNT_FULL);
    assign do_pop = i_report_consume && (count_reg != HPPM_COUNT_ZERO);
    always_comb begin
        count_next = count_reg;
        if (do_push && !do_pop) begin
            count_next = count_reg + HPPM_COUNT_STEP;
        end else if (do_pop && !do_push) begin
            count_next = count_reg - HPPM_COUNT_STEP;
        end
    end
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= HPPM_COUNT_ZERO;
        end else if (i_ce) begin
            count_reg <= count_next;
        end
    end
    assign pending = (count_reg != HPPM_COUNT_ZERO);
    assign o_reports_pending = count_reg;

    // interrupt pin: open drain, low when pending, or in lin with irq as enable low when transceiver enabled
    assign irq_as_enable = is_lin && i_lin_irq_as_enable;
    assign o_report_pending_irq_n = 1'b0;
    assign o_report_pending_irq_n_oe_n = irq_as_enable
        ? ~i_lin_transceiver_enable
        : ~pending;

    // shared pin a
    assign o_host_shared_pin_a = i_i2c_sda_out & 1'b0;
    assign o_host_shared_pin_a_oe_n = ~(is_i2c && i_i2c_sda_drive_low);
    assign o_i2c_sda_in = is_i2c ? sync.pin_a : 1'b1;
    assign o_spi_sck = is_spi ? sync.pin_a : 1'b0;
    assign o_lin_rx = is_lin ? sync.pin_a : 1'b1;

    // shared pin b
    assign o_host_shared_pin_b = is_lin ? i_lin_tx : 1'b0;
    assign o_host_shared_pin_b_oe_n = ~(is_lin || (is_i2c && i_i2c_scl_drive_low));
    assign o_i2c_scl_in = is_i2c ? sync.pin_b : 1'b1;
    assign o_spi_select_n = is_spi ? sync.pin_b : 1'b1;
    assign o_mode = mode_reg;

    // general purpose pins
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_dir_reg <= HPPM_GPIO_DIR_RST;
            gpio_out_reg <= HPPM_GPIO_OUT_RST;
            gpio_in_reg <= HPPM_GPIO_OUT_RST;
            sync_reg <= HPPM_SYNC_RST;
        end else if (i_ce) begin
            gpio_dir_reg <= i_gpio_dir_out;
            gpio_out_reg <= i_gpio_value;
            gpio_in_reg <= sync.gpio;
            sync_reg <= {i_external_sync_enable & sync.gpio[HPPM_VSYNC_BIT],
                         i_hsync_enable & sync.gpio[HPPM_HSYNC_BIT]};
        end
    end
    genvar g;
    generate
        for (g = 0; g < HPPM_GPIO_W; g++) begin : g_gpio
            assign o_gpio[g] = gpio_out_reg[g];
            assign o_gpio_oe_n[g] = ~gpio_dir_reg[g];
        end
    endgenerate
    assign o_gpio_value = gpio_in_reg;
    assign o_hsync = sync_reg[0];
    assign o_external_sync_in = sync_reg[1];
endmodule // hppm_top
`default_nettype wire

// file: hdl/hppm_pkg.sv
// package: host pin mux constants and types
package hppm_pkg;
    typedef enum logic [2:0] {
        HPPM_MODE_I2C = 3'b001,
        HPPM_MODE_SPI = 3'b010,
        HPPM_MODE_LIN = 3'b100
    } hppm_mode_e;
    localparam int HPPM_GPIO_W = 3;
    localparam int HPPM_HSYNC_BIT = 1;
    localparam int HPPM_VSYNC_BIT = 2;
    localparam logic [1:0] HPPM_MODE_SEL_I2C = 2'h0;
    localparam logic [1:0] HPPM_MODE_SEL_SPI = 2'h1;
    localparam logic [1:0] HPPM_MODE_SEL_LIN = 2'h2;
    localparam logic [HPPM_GPIO_W-1:0] HPPM_GPIO_DIR_RST = 3'h0;
    localparam logic [HPPM_GPIO_W-1:0] HPPM_GPIO_OUT_RST = 3'h0;
    localparam logic [1:0] HPPM_SYNC_RST = 2'h0;
    localparam logic [1:0] HPPM_RST_SYNC_INIT = 2'h0;
    localparam logic [1:0] HPPM_RST_SYNC_DONE = 2'h3;
    localparam logic [7:0] HPPM_COUNT_ZERO = 8'h00;
    localparam logic [7:0] HPPM_COUNT_FULL = 8'hff;
    localparam logic [7:0] HPPM_COUNT_STEP = 8'h01;
    localparam logic [4:0] HPPM_PIN_SYNC_RST = 5'h1f;
endpackage : hppm_pkg

// file: hdl/hppm_sync_if.sv
// interface: synchronised pin inputs between top and synchroniser
`timescale 1ns/10ps
`default_nettype none
interface hppm_sync_if;
    logic pin_a;
    logic pin_b;
    logic [2:0] gpio;
    modport src (output pin_a, output pin_b, output gpio);
    modport dst (input pin_a, input pin_b, input gpio);
endinterface : hppm_sync_if
`default_nettype wire

// file: hdl/hppm_sync2.sv
// module: two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module hppm_sync2 (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_pin_a,
    input wire logic i_pin_b,
    input wire logic [2:0] i_gpio,
    hppm_sync_if.src sync
);
    import hppm_pkg::*;

    logic [4:0] meta_reg;
    logic [4:0] stable_reg;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= HPPM_PIN_SYNC_RST;
            stable_reg <= HPPM_PIN_SYNC_RST;
        end else if (i_ce) begin
            meta_reg <= {i_gpio, i_pin_b, i_pin_a};
            stable_reg <= meta_reg;
        end
    end
    assign sync.pin_a = stable_reg[0];
    assign sync.pin_b = stable_reg[1];
    assign sync.gpio = stable_reg[4:2];
endmodule // hppm_sync2
`default_nettype wire

// file: bench/hppm_host_model.sv
// host and transceiver side of shared pin a and the interrupt pin, with pull-ups
`timescale 1ns/10ps
`default_nettype none
module hppm_host_model (
    // device side
    input wire logic i_dev_a, i_dev_a_oe_n, i_irq, i_irq_oe_n,
    // host side
    input wire logic i_host_a_low,
    output logic o_pin_a,
    output logic o_irq_level
);
    assign o_pin_a = ((!i_dev_a_oe_n && !i_dev_a) || i_host_a_low) ? 1'b0 : 1'b1;
    assign o_irq_level = (!i_irq_oe_n && !i_irq) ? 1'b0 : 1'b1;
endmodule // hppm_host_model
`default_nettype wire

// file: bench/hppm_top_asserts.sv
// assertions on the host pin mux top ports
`timescale 1ns/10ps
`default_nettype none
module hppm_top_asserts (
    // clock, reset, requests
    input wire logic i_clk, i_arst_n, i_ce, i_report_push, i_report_consume,
    // core side and config
    input wire logic i_i2c_sda_drive_low, i_lin_tx, i_lin_irq_as_enable,
    input wire logic [2:0] i_gpio_dir_out,
    // pin side
    input wire logic o_host_shared_pin_a_oe_n, o_host_shared_pin_b, o_host_shared_pin_b_oe_n,
    input wire logic o_report_pending_irq_n_oe_n,
    input wire logic [2:0] o_mode, o_gpio_oe_n,
    input wire logic [7:0] o_reports_pending
);
    logic [2:0] age_reg;
    logic up;
    logic irq_en;
    assign up = age_reg == 3'h4;
    assign irq_en = o_mode[2] && i_lin_irq_as_enable;
    // requests are taken only once the internal reset has let go
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            age_reg <= 3'h0;
        else if (!up && i_ce)
            age_reg <= age_reg + 3'h1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    AST_IRQ_LOW: assert property (!irq_en && o_reports_pending != 8'h0 |-> !o_report_pending_irq_n_oe_n)
        else $error("irq not driven with reports pending");
    AST_IRQ_FREE: assert property (!irq_en && o_reports_pending == 8'h0 |-> o_report_pending_irq_n_oe_n)
        else $error("irq driven with no report pending");
    AST_CONSUME: assert property (up && i_ce && i_report_consume && !i_report_push
        && o_reports_pending != 8'h0 |=> o_reports_pending == $past(o_reports_pending) - 8'h1)
        else $error("consume did not drop the count");
    AST_PUSH: assert property (up && i_ce && i_report_push && !i_report_consume
        && o_reports_pending != 8'hff |=> o_reports_pending == $past(o_reports_pending) + 8'h1)
        else $error("push did not raise the count");
    AST_MODE_HOLD: assert property (up |=> $stable(o_mode))
        else $error("mode changed after latch");
    AST_PIN_A: assert property (o_host_shared_pin_a_oe_n == !(o_mode == 3'h1 && i_i2c_sda_drive_low))
        else $error("pin a drive wrong for mode");
    AST_PIN_B_LIN: assert property (o_mode == 3'h4 |-> !o_host_shared_pin_b_oe_n && o_host_shared_pin_b == i_lin_tx)
        else $error("pin b not lin transmit");
    AST_GPIO_DIR: assert property (up && i_ce |=> o_gpio_oe_n == ~$past(i_gpio_dir_out))
        else $error("gpio direction not taken");
endmodule // hppm_top_asserts
`default_nettype wire

// file: bench/hppm_top_tb.sv
// testbench for the host pin mux
`timescale 1ns/10ps
`default_nettype none
module hppm_top_tb;
    import hppm_pkg::*;
    logic i_clk = 0, i_arst_n = 0, i_ce = 1, i_report_push = 0, i_report_consume = 0;
    logic i_lin_irq_as_enable = 0, i_lin_transceiver_enable = 0, i_i2c_sda_drive_low = 0;
    logic i_lin_tx = 0, host_a_low = 0, host_b_low = 0, i_hsync_enable = 0, i_external_sync_enable = 0;
    logic i_i2c_scl_drive_low = 0, o_i2c_scl_in;
    logic [1:0] i_mode_sel = 2'h0;
    logic [2:0] o_gpio;
    logic [2:0] i_gpio = 3'h7, i_gpio_dir_out = 3'h0, i_gpio_value = 3'h0;
    logic o_host_shared_pin_a, o_host_shared_pin_a_oe_n, o_host_shared_pin_b, o_host_shared_pin_b_oe_n;
    logic o_report_pending_irq_n, o_report_pending_irq_n_oe_n, o_i2c_sda_in, o_spi_sck;
    logic o_spi_select_n, o_lin_rx, o_hsync, o_external_sync_in, pin_a, pin_b, irq_lvl;
    logic [2:0] o_mode, o_gpio_oe_n, o_gpio_value;
    logic [7:0] o_reports_pending;
    int num_errors = 0;
    int tests_run = 0;
    assign pin_b = !o_host_shared_pin_b_oe_n ? o_host_shared_pin_b : !host_b_low;
    always #2 i_clk = ~i_clk;
    hppm_top DUT (.i_clk, .i_arst_n, .i_ce, .i_mode_sel, .i_report_push, .i_report_consume,
        .i_lin_irq_as_enable, .i_lin_transceiver_enable, .i_host_shared_pin_a(pin_a),
        .o_host_shared_pin_a, .o_host_shared_pin_a_oe_n, .i_host_shared_pin_b(pin_b),
        .o_host_shared_pin_b, .o_host_shared_pin_b_oe_n, .o_report_pending_irq_n,
        .o_report_pending_irq_n_oe_n, .i_i2c_sda_out(1'b0), .i_i2c_sda_drive_low,
        .i_i2c_scl_drive_low, .i_lin_tx, .o_i2c_sda_in, .o_i2c_scl_in, .o_spi_sck,
        .o_spi_select_n, .o_lin_rx, .o_mode, .o_reports_pending, .i_gpio, .o_gpio,
        .o_gpio_oe_n, .i_gpio_dir_out, .i_gpio_value, .o_gpio_value, .i_hsync_enable,
        .i_external_sync_enable, .o_hsync, .o_external_sync_in);
    hppm_host_model u_host (.i_dev_a(o_host_shared_pin_a), .i_dev_a_oe_n(o_host_shared_pin_a_oe_n),
        .i_irq(o_report_pending_irq_n), .i_irq_oe_n(o_report_pending_irq_n_oe_n),
        .i_host_a_low(host_a_low), .o_pin_a(pin_a), .o_irq_level(irq_lvl));
    task cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rst(input logic [1:0] m);
        i_mode_sel = m;
        i_arst_n = 1'b0;
        cyc(20);
        i_arst_n = 1'b1;
        cyc(4);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #10000;
        num_errors++;
        finish_test;
    end
    initial begin
        rst(HPPM_MODE_SEL_I2C);
        chk({5'h0, o_mode}, 8'h1);
        chk({5'h0, o_gpio_oe_n}, 8'h7);
        chk({7'h0, irq_lvl}, 8'h1);
        i_ce = 1'b0;
        i_report_push = 1'b1;
        cyc(2);
        chk(o_reports_pending, 8'h0);
        i_ce = 1'b1;
        cyc(3);
        chk(o_reports_pending, 8'h3);
        chk({7'h0, irq_lvl}, 8'h0);
        i_report_consume = 1'b1;
        cyc(1);
        i_report_push = 1'b0;
        chk(o_reports_pending, 8'h3);
        cyc(2);
        chk({7'h0, irq_lvl}, 8'h0);
        cyc(2);
        i_report_consume = 1'b0;
        chk(o_reports_pending, 8'h0);
        chk({7'h0, irq_lvl}, 8'h1);
        $display("test reports done");
        i_i2c_sda_drive_low = 1'b1;
        i_i2c_scl_drive_low = 1'b1;
        i_gpio_value = 3'h3;
        i_mode_sel = HPPM_MODE_SEL_LIN;
        i_gpio_dir_out = 3'h5;
        i_gpio = 3'h6;
        i_hsync_enable = 1'b1;
        cyc(2);
        chk({7'h0, pin_a}, 8'h0);
        chk({5'h0, o_mode}, 8'h1);
        chk({5'h0, o_gpio_oe_n}, 8'h2);
        chk({5'h0, o_gpio}, 8'h3);
        chk({7'h0, pin_b}, 8'h0);
        chk({7'h0, o_i2c_scl_in}, 8'h0);
        i_i2c_sda_drive_low = 1'b0;
        i_i2c_scl_drive_low = 1'b0;
        host_a_low = 1'b1;
        cyc(6);
        chk({7'h0, o_i2c_sda_in}, 8'h0);
        chk({7'h0, o_i2c_scl_in}, 8'h1);
        chk({5'h0, o_gpio_value}, 8'h6);
        chk({6'h0, o_external_sync_in, o_hsync}, 8'h1);
        i_external_sync_enable = 1'b1;
        cyc(3);
        chk({7'h0, o_external_sync_in}, 8'h1);
        $display("test i2c and gpio done");
        rst(HPPM_MODE_SEL_LIN);
        i_lin_irq_as_enable = 1'b1;
        i_lin_transceiver_enable = 1'b1;
        cyc(3);
        chk({5'h0, o_mode}, 8'h4);
        chk({7'h0, pin_b}, 8'h0);
        chk({6'h0, o_lin_rx, irq_lvl}, 8'h0);
        i_lin_tx = 1'b1;
        cyc(1);
        chk({7'h0, pin_b}, 8'h1);
        host_b_low = 1'b1;
        rst(HPPM_MODE_SEL_SPI);
        host_a_low = 1'b0;
        cyc(4);
        chk({5'h0, o_spi_sck, o_spi_select_n, irq_lvl}, 8'h5);
        rst(2'h3);
        chk({5'h0, o_mode}, 8'h1);
        $display("test lin and spi done");
        finish_test;
    end
endmodule // hppm_top_tb
bind hppm_top hppm_top_asserts u_asserts (.i_clk, .i_arst_n, .i_ce, .i_report_push,
    .i_report_consume, .i_i2c_sda_drive_low, .i_lin_tx, .i_lin_irq_as_enable, .i_gpio_dir_out,
    .o_host_shared_pin_a_oe_n, .o_host_shared_pin_b, .o_host_shared_pin_b_oe_n,
    .o_report_pending_irq_n_oe_n, .o_mode, .o_gpio_oe_n, .o_reports_pending);
`default_nettype wire
